/* hdl/abwc_top.sv */
/*
 area bus width configuration: per-area bus control and wait control
 registers over apb, width decode, type decode, prohibited flags.
 assumes a single 125 MHz clock and an apb master on the same clock.
*/
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "abwc_cfg.svh"
module abwc_top
   import abwc_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST_B,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output      logic [31:0] PRDATA,
   output      logic        PREADY,
   output      logic        PSLVERR,
   input  wire logic [1:0]  AREA_ZERO_WIDTH_PIN,
   output      logic [15:0] AREA_WIDTH,
   output      logic [23:0] AREA_MEM_TYPE,
   output      logic        AREA3_BANK_ACTIVE,
   output      logic [7:0]  AREA_BAD_CFG
);
   ////////////////////////////////////////////////////////////////////
   // storage and wires
   logic [31:0] bcr_reg [0:7];
   logic [31:0] wcr_reg [0:7];
   logic        bank_active_enable_reg;
   logic [1:0]  pin_s1_reg;
   logic [1:0]  pin_s2_reg;
   logic [31:0] prdata_reg;
   logic [1:0]  width_w [0:7];
   logic [7:0]  bad_w;
   logic [7:0]  type_bad_w;
   wire         acc;
   wire         wr;
   wire         is_bcr;
   wire         is_wcr;
   wire         is_stat;
   wire         is_sdctl;
   wire  [2:0]  idx;
   wire         hit;

   // legal memory types per area (0,2,3,4,5a,5b,6a,6b)
   function automatic logic type_ok(input logic [2:0] a,
                                    input logic [2:0] t);
      logic ok;
      ok = 1'b0;
      unique case (t)
         ABWC_MEM_NORMAL: ok = 1'b1;
         ABWC_MEM_BROM:   ok = (a == 3'h0) | (a == 3'h3);
         ABWC_MEM_MUXIO:  ok = (a == 3'h5);
         ABWC_MEM_BSRAM:  ok = (a == 3'h3) | (a == 3'h5);
         ABWC_MEM_SDRAM:  ok = (a == 3'h1) | (a == 3'h2);
         default:         ok = 1'b0;
      endcase
      return ok;
   endfunction : type_ok

   ////////////////////////////////////////////////////////////////////
   // apb decode
   assign acc      = PSEL & PENABLE;
   assign wr       = acc & PWRITE;
   assign idx      = PADDR[4:2];
   assign is_bcr   = (PADDR[11:5] == 7'(`ABWC_BCR_BASE >> 5)) &
                     (PADDR[1:0] == 2'h0);
   assign is_wcr   = (PADDR[11:5] == 7'(`ABWC_WCR_BASE >> 5)) &
                     (PADDR[1:0] == 2'h0);
   assign is_stat  = (PADDR == `ABWC_STAT_OFS);
   assign is_sdctl = (PADDR == `ABWC_SDCTL_OFS);
   assign hit      = is_bcr | is_wcr | is_stat | is_sdctl;
   assign PREADY   = 1'b1;
   assign PSLVERR  = acc & ~hit;
   assign PRDATA   = prdata_reg;

   ////////////////////////////////////////////////////////////////////
   // per-area decode
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_area
         abwc_area_decode u_dec (
            .AREA_IDX  (3'(g)),
            .FIELD     (bcr_reg[g][`ABWC_WIDTH_MSB:`ABWC_WIDTH_LSB]),
            .PIN_WIDTH (pin_s2_reg),
            .WIDTH     (width_w[g]),
            .BAD       (bad_w[g])
         );
         // memory type field selects wait register layout downstream
         assign AREA_MEM_TYPE[3*g +: 3] =
            bcr_reg[g][`ABWC_TYPE_MSB:`ABWC_TYPE_LSB];
         assign type_bad_w[g] = ~type_ok(3'(g),
            bcr_reg[g][`ABWC_TYPE_MSB:`ABWC_TYPE_LSB]);
         assign AREA_WIDTH[2*g +: 2] = width_w[g];
      end
   endgenerate

   // flags, shown to software and to the bus controller
   assign AREA_BAD_CFG = bad_w | type_bad_w;
   // bank-active only takes effect for area 3 (index 2) as sdram
   assign AREA3_BANK_ACTIVE = bank_active_enable_reg &
      (bcr_reg[2][`ABWC_TYPE_MSB:`ABWC_TYPE_LSB] == ABWC_MEM_SDRAM);

   ////////////////////////////////////////////////////////////////////
   // width pin synchroniser
   always_ff @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         pin_s1_reg <= 2'h0;
         pin_s2_reg <= 2'h0;
      end
      else
      begin
         pin_s1_reg <= AREA_ZERO_WIDTH_PIN;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register writes; bcr reserved bits masked off, wcr stored as written
   always_ff @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         for (int i = 0; i < 8; i++)
         begin
            bcr_reg[i] <= (i >= 5) ? `ABWC_BCR_RST_NARROW
                                   : `ABWC_BCR_RST_WIDE;
            wcr_reg[i] <= `ABWC_WCR_RST;
         end
         bank_active_enable_reg <= 1'b0;
      end
      else if (wr)
      begin
         if (is_bcr)
            bcr_reg[idx] <= PWDATA & `ABWC_BCR_KEEP;
         if (is_wcr)
            wcr_reg[idx] <= PWDATA;
         if (is_sdctl)
            bank_active_enable_reg <= PWDATA[0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read data captured at the end of the setup phase
   always_ff @(posedge SYS_CLK or negedge RST_B)
   begin
      if (!RST_B)
         prdata_reg <= 32'h0;
      else if (PSEL & ~PENABLE & ~PWRITE)
      begin
         if (is_bcr)
            prdata_reg <= bcr_reg[idx] & `ABWC_BCR_KEEP;
         else if (is_wcr)
            prdata_reg <= wcr_reg[idx];
         else if (is_stat)
            prdata_reg <= {24'h0, AREA_BAD_CFG};
         else if (is_sdctl)
            prdata_reg <= {31'h0, bank_active_enable_reg};
         else
            prdata_reg <= 32'h0;
      end
   end
endmodule : abwc_top

/* hdl/abwc_cfg.svh */
/*
 area bus width configuration: register offsets, field positions,
 reset values. assumes inclusion by abwc_top and abwc_area_decode.
*/
`ifndef ABWC_CFG_SVH
`define ABWC_CFG_SVH
`define ABWC_NUM_AREAS      8
`define ABWC_BCR_BASE       12'h000
`define ABWC_WCR_BASE       12'h040
`define ABWC_STAT_OFS       12'h080
`define ABWC_SDCTL_OFS      12'h084
`define ABWC_TYPE_MSB       14
`define ABWC_TYPE_LSB       12
`define ABWC_WIDTH_MSB      10
`define ABWC_WIDTH_LSB      9
`define ABWC_BCR_WMASK      32'h000076FF
`define ABWC_BCR_KEEP       32'h00007600
`define ABWC_BCR_RST_WIDE   32'h00000600
`define ABWC_BCR_RST_NARROW 32'h00000000
`define ABWC_WCR_RST        32'h00000500
`endif

/* hdl/abwc_pkg.sv */
/*
 types for the area bus width configuration block.
 assumes abwc_cfg.svh is on the include path.
*/
package abwc_pkg;
   typedef enum logic [2:0] {
      ABWC_MEM_NORMAL = 3'h0,
      ABWC_MEM_BROM   = 3'h1,
      ABWC_MEM_MUXIO  = 3'h2,
      ABWC_MEM_BSRAM  = 3'h3,
      ABWC_MEM_SDRAM  = 3'h4
   } abwc_mem_e;
   typedef logic [1:0] abwc_width_t; // 01 8-bit, 10 16-bit, 11 32-bit
endpackage : abwc_pkg

/* hdl/abwc_area_decode.sv */
/*
 per-area width decode: resolves width code and prohibited flag.
 assumes the width field comes from the register file and the area index from the generate loop.
*/
`timescale 1ns/1ps
`include "abwc_cfg.svh"
module abwc_area_decode
   import abwc_pkg::*;
(
   input  wire logic [2:0] AREA_IDX,
   input  wire logic [1:0] FIELD,
   input  wire logic [1:0] PIN_WIDTH,
   output      logic [1:0] WIDTH,
   output      logic       BAD
);
   wire narrow_area;
   wire [1:0] eff;
   // areas 5b, 6a, 6b (indices 5..7) have no 32-bit mode
   assign narrow_area = (AREA_IDX >= 3'h5);
   // area 0 width comes only from the pin
   assign eff   = (AREA_IDX == 3'h0) ? PIN_WIDTH : FIELD;
   assign WIDTH = eff;
   // 00 prohibited everywhere, 11 prohibited on narrow areas
   assign BAD   = (eff == 2'h0) | (narrow_area & (eff == 2'h3));
endmodule : abwc_area_decode

/* sim/abwc_chk_asserts.sv */
/* port checks for abwc_top
 assumes apb master and strap pin on SYS_CLK */
`timescale 1ns/1ps
module abwc_chk (
   input wire logic        SYS_CLK,
   input wire logic        RST_B,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic [1:0]  AREA_ZERO_WIDTH_PIN,
   input wire logic [15:0] AREA_WIDTH,
   input wire logic [23:0] AREA_MEM_TYPE,
   input wire logic        AREA3_BANK_ACTIVE,
   input wire logic [7:0]  AREA_BAD_CFG
);
   // one domain, reset low disables
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);
   property p_w1; AREA_WIDTH[3:2] == 2'h0 |-> AREA_BAD_CFG[1]; endproperty
   property p_w2; AREA_WIDTH[11:10] == 2'h3 |-> AREA_BAD_CFG[5]; endproperty
   property p_wd; PSEL && PENABLE && PWRITE && PADDR == 12'h004
      |=> AREA_WIDTH[3:2] == $past(PWDATA[10:9]); endproperty
   property p_rz; PSEL && PENABLE && !PWRITE && PADDR < 12'h040
      |-> PRDATA[8:0] == 9'h0; endproperty
   property p_pin; (RST_B && $stable(AREA_ZERO_WIDTH_PIN))[*3]
      |-> AREA_WIDTH[1:0] == AREA_ZERO_WIDTH_PIN; endproperty
   property p_bk; AREA3_BANK_ACTIVE |-> AREA_MEM_TYPE[8:6] == 3'h4; endproperty
   property p_rs; $rose(RST_B) |-> AREA_BAD_CFG[7:5] == 3'h7; endproperty
   property p_ty; PSEL && PENABLE && PWRITE && PADDR == 12'h00C
      |=> AREA_MEM_TYPE[11:9] == $past(PWDATA[14:12]); endproperty
   a_w1: assert property (p_w1) else $error("w1");
   a_w2: assert property (p_w2) else $error("w2");
   a_wd: assert property (p_wd) else $error("wd");
   a_rz: assert property (p_rz) else $error("rz");
   a_pin: assert property (p_pin) else $error("pin");
   a_bk: assert property (p_bk) else $error("bk");
   a_rs: assert property (p_rs) else $error("rs");
   a_ty: assert property (p_ty) else $error("ty");
   cover property (AREA3_BANK_ACTIVE);
   cover property (PSLVERR);
   cover property (AREA_BAD_CFG[5]);
endmodule : abwc_chk
bind abwc_top abwc_chk i_abwc_chk (.*);

/* sim/abwc_strap.sv */
/* strap model of the area zero width pin
 assumes the bench picks the code */
`timescale 1ns/1ps
module abwc_strap (
   input  wire logic [1:0] code,
   output      logic [1:0] pin
);
   assign pin = code; // board strap straight onto pin
endmodule : abwc_strap

/* sim/area_bus_width_config_bench.sv */
/* bench for abwc_top
 assumes abwc_chk bound and strap model */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
 err_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module area_bus_width_config_bench;
   logic SYS_CLK = 1'h0, RST_B = 1'h0, PSEL = 1'h0, PENABLE = 1'h0;
   logic PWRITE = 1'h0, PREADY, PSLVERR, slv, AREA3_BANK_ACTIVE;
   logic [11:0] PADDR = 12'h0;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic [1:0]  strap = 2'h2, AREA_ZERO_WIDTH_PIN;
   logic [15:0] AREA_WIDTH;
   logic [23:0] AREA_MEM_TYPE;
   logic [7:0]  AREA_BAD_CFG;
   int          err_count = 0, samples_checked = 0, cyc = 0, i;
   abwc_top i_abwc_top (.*);
   abwc_strap i_abwc_strap (.code(strap), .pin(AREA_ZERO_WIDTH_PIN));
   initial forever #4 SYS_CLK = ~SYS_CLK;
   // hang guard
   always @(posedge SYS_CLK)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         final_report();
      end
   end
   task final_report;
      $display("errors %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report
   // one apb transfer, held until pready
   task xf(input logic w, input logic [11:0] a, input logic [31:0] d);
      PSEL <= 1'h1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'h1;
      @(posedge SYS_CLK);
      while (PREADY !== 1'h1) @(posedge SYS_CLK);
      rd = PRDATA;
      slv = PSLVERR;
      PSEL <= 1'h0;
      PENABLE <= 1'h0;
      @(posedge SYS_CLK);
   endtask : xf
   initial
   begin
      repeat (5) @(posedge SYS_CLK);
      RST_B <= 1'h1;
      repeat (3) @(posedge SYS_CLK);
      `CHK(AREA_BAD_CFG[7:5], 3'h7)
      `CHK(AREA_WIDTH[1:0], 2'h2)
      xf(1'h1, 12'h000, 32'h200);
      `CHK(AREA_WIDTH[1:0], 2'h2)
      xf(1'h0, 12'h014, 32'h0);
      `CHK(rd, 32'h0)
      xf(1'h1, 12'h048, 32'hA5A5A5A5);
      xf(1'h0, 12'h048, 32'h0);
      `CHK(rd, 32'hA5A5A5A5)
      xf(1'h1, 12'h008, 32'hFFFFFFFF);
      xf(1'h0, 12'h008, 32'h0);
      `CHK(rd, 32'h7600)
      for (i = 0; i < 4; i++)
      begin
         xf(1'h1, 12'h004, i << 9);
         xf(1'h1, 12'h014, i << 9);
         `CHK(AREA_BAD_CFG[1], i == 0)
         `CHK(AREA_BAD_CFG[5], i == 0 || i == 3)
      end
      for (i = 0; i < 5; i++)
      begin
         xf(1'h1, 12'h00C, (i << 12) | 32'h400);
         `CHK(AREA_MEM_TYPE[11:9], 3'(i))
      end
      xf(1'h1, 12'h084, 32'h1);
      xf(1'h1, 12'h008, 32'h4400);
      `CHK(AREA3_BANK_ACTIVE, 1'h1)
      xf(1'h1, 12'h008, 32'h400);
      `CHK(AREA3_BANK_ACTIVE, 1'h0)
      xf(1'h0, 12'h0C0, 32'h0);
      `CHK(slv, 1'h1)
      // area 5B muxed io at 16 bits, then its wait register
      xf(1'h1, 12'h014, 32'h2400);
      xf(1'h1, 12'h054, 32'h500);
      `CHK(AREA_BAD_CFG[5], 1'h0)
      `CHK(AREA_MEM_TYPE[17:15], 3'h2)
      xf(1'h0, 12'h054, 32'h0);
      `CHK(rd, 32'h500)
      // areas 2 and 3 both sdram at the same 32-bit width
      xf(1'h1, 12'h004, 32'h4600);
      xf(1'h1, 12'h008, 32'h4600);
      `CHK(AREA_BAD_CFG[2:1], 2'h0)
      `CHK(AREA_WIDTH[5:2], 4'hF)
      `CHK(AREA3_BANK_ACTIVE, 1'h1)
      // unsupported type on area 2 is flagged
      xf(1'h1, 12'h004, 32'h2400);
      `CHK(AREA_BAD_CFG[1], 1'h1)
      xf(1'h0, 12'h080, 32'h0);
      `CHK(rd, 32'hCA)
      xf(1'h0, 12'h084, 32'h0);
      `CHK(rd, 32'h1)
      strap <= 2'h1;
      repeat (4) @(posedge SYS_CLK);
      `CHK(AREA_WIDTH[1:0], 2'h1)
      final_report();
   end
endmodule : area_bus_width_config_bench
